// ---- verilog/olsc_consts.svh ----
`ifndef OLSC_CONSTS_SVH
`define OLSC_CONSTS_SVH
// ***********************************
// command codes
// ***********************************
`define OLSC_CMD_READ_LOCK 8'h2b
`define OLSC_CMD_WRITE_LOCK 8'ha3
`define OLSC_CMD_ENTER_OTP 8'ha1
`define OLSC_CMD_LEAVE_OTP 8'ha2
`define OLSC_CMD_PAUSE_EN 8'ha4
`define OLSC_CMD_WRITE_ALLOW 8'ha5
// ***********************************
// lock status fields
// ***********************************
`define OLSC_BIT_FACTORY 0
`define OLSC_BIT_LOCK 1
`define OLSC_BIT_CP 4
`define OLSC_STATUS_RESET 8'h00
`define OLSC_OTP_BITS 512
`endif

// ---- verilog/olsc_pkg.sv ----
`default_nettype none
package olsc_pkg;
   typedef enum logic [1:0] {
      OLSC_IDLE = 2'b00,
      OLSC_CMD = 2'b01,
      OLSC_READ = 2'b10,
      OLSC_SKIP = 2'b11
   } olsc_phase_e;

   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic cs_d;
      logic sck_s1;
      logic sck_s2;
      logic sck_d;
      logic si_s1;
      logic si_s2;
      logic pin_s1;
      logic pin_s2;
      logic [2:0] bit_cnt;
      logic [1:0] nbytes;
      logic [7:0] sh;
      logic sel;
      logic fall;
      logic byte_done;
      logic [7:0] byte_val;
      logic frame_end;
      logic boundary;
   } olsc_shift_s;

   typedef struct packed {
      olsc_phase_e phase;
      logic [7:0] cmd;
      logic [2:0] out_idx;
      logic otp_mode;
      logic lock_bit;
      logic factory_bit;
      logic cp_bit;
      logic write_latch_flag;
      logic pause_mode;
      logic so;
      logic so_oe;
      logic dev_reset;
      logic pause;
      logic main_block;
      logic prog_block;
      logic [7:0] status;
   } olsc_ctrl_s;
endpackage : olsc_pkg
`default_nettype wire

// ---- verilog/olsc_link_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface olsc_link_if;
   logic sel;
   logic fall;
   logic byte_done;
   logic [7:0] byte_val;
   logic frame_end;
   logic boundary;
   logic pin_low;
   modport src (output sel, fall, byte_done, byte_val, frame_end, boundary, pin_low);
   modport dst (input sel, fall, byte_done, byte_val, frame_end, boundary, pin_low);
endinterface : olsc_link_if
`default_nettype wire

// ---- verilog/olsc_shift.sv ----
`timescale 1ns/100ps
`default_nettype none
module olsc_shift (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic cs_n_in,
   input wire logic sclk_in,
   input wire logic si_in,
   input wire logic multi_n_in,
   olsc_link_if.src lk
);
   import olsc_pkg::*;

   olsc_shift_s r_reg;
   olsc_shift_s r_next;

   // ***********************************
   // sync, edge find, byte assembly
   // ***********************************
   always_comb
   begin
      r_next = r_reg;
      r_next.cs_s1 = cs_n_in;
      r_next.cs_s2 = r_reg.cs_s1;
      r_next.cs_d = r_reg.cs_s2;
      r_next.sck_s1 = sclk_in;
      r_next.sck_s2 = r_reg.sck_s1;
      r_next.sck_d = r_reg.sck_s2;
      r_next.si_s1 = si_in;
      r_next.si_s2 = r_reg.si_s1;
      r_next.pin_s1 = multi_n_in;
      r_next.pin_s2 = r_reg.pin_s1;
      r_next.sel = !r_reg.cs_s2;
      r_next.fall = 1'b0;
      r_next.byte_done = 1'b0;
      // boundary judged on counts before they are cleared
      r_next.frame_end = r_reg.cs_s2 && !r_reg.cs_d;
      r_next.boundary = (r_reg.bit_cnt == 3'h0) && (r_reg.nbytes == 2'h1);
      if (r_reg.cs_s2)
      begin
         r_next.bit_cnt = 3'h0;
         r_next.nbytes = 2'h0;
      end
      else if (r_reg.sck_s2 && !r_reg.sck_d)
      begin
         r_next.sh = {r_reg.sh[6:0], r_reg.si_s2};
         r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
         if (r_reg.bit_cnt == 3'h7)
         begin
            r_next.byte_done = 1'b1;
            r_next.byte_val = {r_reg.sh[6:0], r_reg.si_s2};
            // saturate: only "exactly one byte" matters
            if (r_reg.nbytes != 2'h3)
               r_next.nbytes = r_reg.nbytes + 2'h1;
         end
      end
      else if (!r_reg.sck_s2 && r_reg.sck_d)
         r_next.fall = 1'b1;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         r_reg <= '0;
         r_reg.cs_s1 <= 1'b1;
         r_reg.cs_s2 <= 1'b1;
         r_reg.cs_d <= 1'b1;
         r_reg.pin_s1 <= 1'b1;
         r_reg.pin_s2 <= 1'b1;
      end
      else
         r_reg <= r_next;
   end

   assign lk.sel = r_reg.sel;
   assign lk.fall = r_reg.fall;
   assign lk.byte_done = r_reg.byte_done;
   assign lk.byte_val = r_reg.byte_val;
   assign lk.frame_end = r_reg.frame_end;
   assign lk.boundary = r_reg.boundary;
   assign lk.pin_low = !r_reg.pin_s2;

   a_byte_count: assert property (@(posedge clk_in) disable iff (rst_in)
      r_reg.frame_end && r_reg.boundary |-> $past(r_reg.nbytes) == 2'h1)
      else $error("boundary flagged without exactly one byte");
endmodule : olsc_shift
`default_nettype wire

// ---- verilog/olsc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "olsc_consts.svh"
// Operation
// - enter command switches accesses to otp region
// - leave command returns accesses to main array
// - lock status readable any time, repeatedly
// - after read byte, status shifts out until deselect
// - bit 0 reports factory lock, read only
// - write command sets customer lock bit
// - locked bit blocks bit changes and otp program
// - otp mode blocks main array access
// - bit 4 shows streaming program mode, default 0
// - streaming end clears latch and bit 4
// - lock write needs no write allow
// - lock write rejected unless select rises on boundary
// - in otp mode lock write ignored
// - shared pin is reset input after power on
// - pause enable makes pin pause until power off
// - pause enable ignored in deep power down
// - power up lands in standby, selectable
// - power on reset clears write latch
module olsc_top (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic cs_n_in,
   input wire logic sclk_in,
   input wire logic si_in,
   input wire logic multi_n_in,
   input wire logic factory_lock_in,
   input wire logic nv_lock_in,
   input wire logic deep_pd_in,
   input wire logic cp_start_in,
   input wire logic cp_end_in,
   output logic so_out,
   output logic so_oe_out,
   output logic otp_mode_out,
   output logic main_block_out,
   output logic otp_prog_block_out,
   output logic write_latch_out,
   output logic pause_mode_out,
   output logic dev_reset_out,
   output logic pause_out,
   output logic [7:0] lock_status_out
);
   import olsc_pkg::*;

   olsc_ctrl_s r_reg;
   olsc_ctrl_s r_next;

   olsc_link_if lk ();

   olsc_shift olsc_shift_i (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .cs_n_in(cs_n_in),
      .sclk_in(sclk_in),
      .si_in(si_in),
      .multi_n_in(multi_n_in),
      .lk(lk)
   );

   // ***********************************
   // command decode and status
   // ***********************************
   always_comb
   begin
      r_next = r_reg;
      // streaming engine events; clear first so a later set wins
      if (cp_end_in)
      begin
         r_next.cp_bit = 1'b0;
         r_next.write_latch_flag = 1'b0;
      end
      if (cp_start_in)
         r_next.cp_bit = 1'b1;
      if (lk.frame_end)
      begin
         r_next.phase = OLSC_IDLE;
         r_next.so_oe = 1'b0;
         r_next.so = 1'b0;
         // deep power down ignores everything executed at deselect
         if (lk.boundary && !deep_pd_in)
         begin
            unique case (r_reg.cmd)
               `OLSC_CMD_ENTER_OTP: r_next.otp_mode = 1'b1;
               `OLSC_CMD_LEAVE_OTP: r_next.otp_mode = 1'b0;
               `OLSC_CMD_WRITE_ALLOW: r_next.write_latch_flag = 1'b1;
               `OLSC_CMD_PAUSE_EN: r_next.pause_mode = 1'b1;
               `OLSC_CMD_WRITE_LOCK:
               begin
                  // no latch check here: this write stands alone
                  if (!r_reg.otp_mode)
                     r_next.lock_bit = 1'b1;
               end
               default: r_next.cmd = r_reg.cmd;
            endcase
         end
      end
      else
      begin
         unique case (r_reg.phase)
            OLSC_IDLE:
               if (lk.sel)
                  r_next.phase = OLSC_CMD;
            OLSC_CMD:
               if (lk.byte_done)
               begin
                  r_next.cmd = lk.byte_val;
                  r_next.out_idx = 3'h0;
                  // read is taken whatever else is busy
                  r_next.phase = (lk.byte_val == `OLSC_CMD_READ_LOCK) ? OLSC_READ
                                                                      : OLSC_SKIP;
               end
            OLSC_READ:
               if (lk.fall)
               begin
                  r_next.so_oe = 1'b1;
                  r_next.so = r_reg.status[3'h7 - r_reg.out_idx];
                  r_next.out_idx = r_reg.out_idx + 3'h1;
               end
            OLSC_SKIP:
               r_next.phase = OLSC_SKIP;
         endcase
      end
      r_next.status = `OLSC_STATUS_RESET;
      r_next.status[`OLSC_BIT_FACTORY] = r_next.factory_bit;
      r_next.status[`OLSC_BIT_LOCK] = r_next.lock_bit;
      r_next.status[`OLSC_BIT_CP] = r_next.cp_bit;
      r_next.main_block = r_next.otp_mode;
      r_next.prog_block = r_next.lock_bit;
      r_next.dev_reset = !r_next.pause_mode && lk.pin_low;
      r_next.pause = r_next.pause_mode && lk.pin_low;
   end

   // straps are caught while reset is held; they are static levels
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         r_reg <= '0;
         r_reg.phase <= OLSC_IDLE;
         r_reg.factory_bit <= factory_lock_in;
         r_reg.lock_bit <= nv_lock_in;
         r_reg.prog_block <= nv_lock_in;
         r_reg.status <= {6'h00, nv_lock_in, factory_lock_in};
      end
      else
         r_reg <= r_next;
   end

   assign so_out = r_reg.so;
   assign so_oe_out = r_reg.so_oe;
   assign otp_mode_out = r_reg.otp_mode;
   assign main_block_out = r_reg.main_block;
   assign otp_prog_block_out = r_reg.prog_block;
   assign write_latch_out = r_reg.write_latch_flag;
   assign pause_mode_out = r_reg.pause_mode;
   assign dev_reset_out = r_reg.dev_reset;
   assign pause_out = r_reg.pause;
   assign lock_status_out = r_reg.status;

   // ***********************************
   // checks
   // ***********************************
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   wire logic exec_ok = lk.frame_end && lk.boundary && !deep_pd_in;

   a_enter_sets_otp: assert property (exec_ok && r_reg.cmd == `OLSC_CMD_ENTER_OTP
      |=> otp_mode_out ##1 main_block_out)
      else $error("enter did not set otp mode");
   a_leave_clears_otp: assert property (exec_ok && r_reg.cmd == `OLSC_CMD_LEAVE_OTP
      |=> !otp_mode_out ##1 !main_block_out)
      else $error("leave did not clear otp mode");
   a_main_blocked: assert property (otp_mode_out |-> main_block_out)
      else $error("main array open in otp mode");
   a_lock_sticky: assert property (lock_status_out[1] |=> lock_status_out[1])
      else $error("customer lock bit cleared");
   a_lock_write_set: assert property (exec_ok && r_reg.cmd == `OLSC_CMD_WRITE_LOCK
      && !otp_mode_out |=> lock_status_out[1] && otp_prog_block_out)
      else $error("lock write not applied");
   // streaming events may move bit 4 at any time, so only the lock bit is held
   a_off_boundary: assert property (lk.frame_end && !lk.boundary
      |=> $stable(lock_status_out[1]))
      else $error("write applied off boundary");
   a_otp_ignores_wr: assert property (lk.frame_end && otp_mode_out
      && r_reg.cmd == `OLSC_CMD_WRITE_LOCK |=> $stable(lock_status_out[1]))
      else $error("lock write taken in otp mode");
   a_rsvd_zero: assert property (lock_status_out[7:5] == 3'h0
      && lock_status_out[3:2] == 2'h0)
      else $error("reserved bit set");
   a_factory_fixed: assert property ($stable(lock_status_out[0]))
      else $error("factory bit changed");
   // a start or a write allow in the same cycle wins over the end
   a_cp_end_clear: assert property (cp_end_in && !cp_start_in
      && !(exec_ok && r_reg.cmd == `OLSC_CMD_WRITE_ALLOW)
      |=> !write_latch_out && !lock_status_out[4])
      else $error("streaming end left flags set");
   a_pause_sticky: assert property (pause_mode_out |=> pause_mode_out)
      else $error("pause function lost");
   a_pause_in_pd: assert property (lk.frame_end && deep_pd_in && !pause_mode_out
      |=> !pause_mode_out)
      else $error("pause enabled in deep power down");
   // a pause enable taking effect at deselect hands the pin over that cycle
   a_reset_pin: assert property (!lk.frame_end && !pause_mode_out && lk.pin_low
      |=> dev_reset_out && !pause_out)
      else $error("shared pin not acting as reset");
   a_read_drives: assert property (r_reg.phase == OLSC_READ && lk.fall
      && !lk.frame_end |=> so_oe_out && so_out == $past(r_reg.status[3'h7 - r_reg.out_idx]))
      else $error("status bit not driven");
   a_por_clears: assert property (@(posedge clk_in) disable iff (1'b0)
      rst_in |=> !write_latch_out && !otp_mode_out && !so_oe_out)
      else $error("power on state wrong");

   c_read: cover property (r_reg.phase == OLSC_READ && lk.fall);
   c_lock: cover property (exec_ok && r_reg.cmd == `OLSC_CMD_WRITE_LOCK);
   c_enter: cover property (exec_ok && r_reg.cmd == `OLSC_CMD_ENTER_OTP);
   c_pause: cover property (exec_ok && r_reg.cmd == `OLSC_CMD_PAUSE_EN);
endmodule : olsc_top
`default_nettype wire

// ---- dv/olsc_host.sv ----
`timescale 1ns/100ps
`default_nettype none
// ***************
// host model
// ***************
module olsc_host (
   input wire logic clk_in,
   input wire logic so_in,
   input wire logic so_oe_in,
   output logic cs_n_out,
   output logic sclk_out,
   output logic si_out
);
   initial
   begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      si_out = 1'b1;
   end

   // one 160 ns serial period; sclk idles low, so sampled just before the fall
   task automatic tick(input logic b, output logic s);
      si_out = b;
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (3) @(negedge clk_in);
      // a released line floats; model it as the inverse of the last level
      s = so_oe_in ? so_in : ~so_in;
      @(negedge clk_in);
      sclk_out = 1'b0;
   endtask : tick

   // nbits other than 8 breaks the byte boundary on purpose
   task automatic frame(input logic [7:0] cmd, input int nbits, input int nrd,
                        output logic [15:0] rd, output logic oe);
      logic s;
      rd = 16'h0000;
      oe = 1'b0;
      @(negedge clk_in);
      cs_n_out = 1'b0;
      for (int i = 0; i < nbits; i++)
         tick((i < 8) ? cmd[7 - i] : 1'b0, s);
      for (int i = 0; i < nrd; i++)
      begin
         tick(1'b0, s);
         rd = {rd[14:0], s};
         oe = so_oe_in;
      end
      cs_n_out = 1'b1;
      si_out = ~si_out; // released line must not keep a stale level
      repeat (8) @(negedge clk_in);
   endtask : frame
endmodule : olsc_host
`default_nettype wire

// ---- dv/olsc_top_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "olsc_consts.svh"
module olsc_top_bench;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic cs_n, sclk, si, so, so_oe, otp_mode, main_blk, prog_blk, wl, pmode, dreset, pause;
   logic multi_n = 1'b1;
   logic fac = 1'b1;
   logic nv = 1'b0;
   logic dpd = 1'b0;
   logic cps = 1'b0;
   logic cpe = 1'b0;
   logic [7:0] status;
   logic [15:0] rd;
   logic oe;
   int err_total = 0;
   int n_compared = 0;

   always #10 clk_in = ~clk_in;

   olsc_top olsc_top_i (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sclk_in(sclk),
      .si_in(si), .multi_n_in(multi_n), .factory_lock_in(fac), .nv_lock_in(nv),
      .deep_pd_in(dpd), .cp_start_in(cps), .cp_end_in(cpe), .so_out(so), .so_oe_out(so_oe),
      .otp_mode_out(otp_mode), .main_block_out(main_blk), .otp_prog_block_out(prog_blk),
      .write_latch_out(wl), .pause_mode_out(pmode), .dev_reset_out(dreset),
      .pause_out(pause), .lock_status_out(status));

   olsc_host olsc_host_i (.clk_in(clk_in), .so_in(so), .so_oe_in(so_oe), .cs_n_out(cs_n),
      .sclk_out(sclk), .si_out(si));

   // ***************
   // helpers
   // ***************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : chk

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test

   task automatic do_reset;
      rst_in = 1'b1;
      repeat (3) @(negedge clk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge clk_in);
   endtask : do_reset

   // one-cycle streaming event: 0 gives a start, 1 an end
   task automatic pulse(input logic which);
      @(negedge clk_in);
      if (which)
         cpe = 1'b1;
      else
         cps = 1'b1;
      @(negedge clk_in);
      cps = 1'b0;
      cpe = 1'b0;
      @(negedge clk_in);
   endtask : pulse

   // ***************
   // scenarios
   // ***************
   task automatic t_power_up;
      chk(status, 8'h01, "status after reset");
      chk({7'h00, wl}, 8'h00, "latch after reset");
      chk({7'h00, otp_mode}, 8'h00, "otp flag after reset");
      chk({7'h00, so_oe}, 8'h00, "so idle");
      $display("done power_up");
   endtask : t_power_up

   task automatic t_read_stream;
      pulse(1'b0);
      chk(status, 8'h11, "stream bit");
      olsc_host_i.frame(`OLSC_CMD_READ_LOCK, 8, 16, rd, oe);
      chk(rd[15:8], 8'h11, "first read byte");
      chk(rd[7:0], 8'h11, "repeated byte");
      chk({7'h00, oe}, 8'h01, "so driven");
      chk({7'h00, so_oe}, 8'h00, "so released");
      olsc_host_i.frame(`OLSC_CMD_WRITE_ALLOW, 8, 0, rd, oe);
      chk({7'h00, wl}, 8'h01, "latch set");
      pulse(1'b1);
      chk(status, 8'h01, "stream end bit");
      chk({7'h00, wl}, 8'h00, "stream end latch");
      $display("done read_stream");
   endtask : t_read_stream

   task automatic t_otp_mode;
      olsc_host_i.frame(`OLSC_CMD_ENTER_OTP, 8, 0, rd, oe);
      chk({7'h00, otp_mode}, 8'h01, "otp entered");
      chk({7'h00, main_blk}, 8'h01, "main blocked");
      olsc_host_i.frame(`OLSC_CMD_WRITE_LOCK, 8, 0, rd, oe);
      chk(status, 8'h01, "write in otp mode");
      olsc_host_i.frame(`OLSC_CMD_LEAVE_OTP, 8, 0, rd, oe);
      chk({7'h00, otp_mode}, 8'h00, "otp left");
      chk({7'h00, main_blk}, 8'h00, "main open");
      $display("done otp_mode");
   endtask : t_otp_mode

   task automatic t_lock_write;
      olsc_host_i.frame(`OLSC_CMD_WRITE_LOCK, 7, 0, rd, oe);
      chk(status, 8'h01, "short frame");
      olsc_host_i.frame(`OLSC_CMD_WRITE_LOCK, 9, 0, rd, oe);
      chk(status, 8'h01, "long frame");
      chk({7'h00, wl}, 8'h00, "no latch");
      olsc_host_i.frame(`OLSC_CMD_WRITE_LOCK, 8, 0, rd, oe);
      chk(status, 8'h03, "lock set");
      chk({7'h00, prog_blk}, 8'h01, "otp program blocked");
      olsc_host_i.frame(`OLSC_CMD_READ_LOCK, 8, 8, rd, oe);
      chk(rd[7:0], 8'h03, "read locked");
      $display("done lock_write");
   endtask : t_lock_write

   task automatic t_pause_pin;
      multi_n = 1'b0;
      repeat (4) @(negedge clk_in);
      chk({6'h00, dreset, pause}, 8'h02, "pin as reset");
      multi_n = 1'b1;
      dpd = 1'b1;
      olsc_host_i.frame(`OLSC_CMD_PAUSE_EN, 8, 0, rd, oe);
      chk({7'h00, pmode}, 8'h00, "pause ignored in power down");
      dpd = 1'b0;
      olsc_host_i.frame(`OLSC_CMD_PAUSE_EN, 8, 0, rd, oe);
      chk({7'h00, pmode}, 8'h01, "pause mode");
      multi_n = 1'b0;
      repeat (4) @(negedge clk_in);
      chk({6'h00, dreset, pause}, 8'h01, "pin as pause");
      multi_n = 1'b1;
      $display("done pause_pin");
   endtask : t_pause_pin

   task automatic t_stored_lock;
      olsc_host_i.frame(`OLSC_CMD_ENTER_OTP, 8, 0, rd, oe);
      olsc_host_i.frame(`OLSC_CMD_WRITE_ALLOW, 8, 0, rd, oe);
      chk({6'h00, otp_mode, wl}, 8'h03, "flags before reset");
      nv = 1'b1;
      do_reset();
      chk({6'h00, otp_mode, wl}, 8'h00, "flags after reset");
      chk(status, 8'h03, "stored lock");
      chk({7'h00, prog_blk}, 8'h01, "stored block");
      chk({7'h00, pmode}, 8'h00, "pin reset after power");
      $display("done stored_lock");
   endtask : t_stored_lock

   initial
   begin
      repeat (20000) @(posedge clk_in);
      err_total++;
      $display("BAD %0t timeout", $time);
      finish_test();
   end

   initial
   begin
      do_reset();
      t_power_up();
      t_read_stream();
      t_otp_mode();
      t_lock_write();
      t_pause_pin();
      t_stored_lock();
      finish_test();
   end
endmodule : olsc_top_bench
`default_nettype wire
